// *** rtl/ssd_pkg.sv ***
package ssd_pkg;
  // Shift chain length
  localparam int STAGES = 8;
  // Reset value of sink outputs, also driven while outputs are off
  localparam logic [7:0] CLEAR_VAL = 8'h00;
  // Link clock limit for guaranteed operation
  localparam int LINK_MAX_KHZ = 10000;
  localparam int MCLK_KHZ = 250000;
  // Half period of generated link clock in MCLK cycles, rounded up
  localparam int LINK_HALF_CYC =
    (MCLK_KHZ + 2 * LINK_MAX_KHZ - 1) / (2 * LINK_MAX_KHZ);
  // Synchroniser length for pin inputs
  localparam int SYNC_LEN = 3;
endpackage

// *** rtl/ssd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ssd_if;
  logic link_clk;
  logic ser_in;
  logic ser_out;
  logic latch_load;
  logic out_off;
  logic [7:0] sink_drive;
  modport dev (
    input  link_clk,
    input  ser_in,
    input  latch_load,
    input  out_off,
    output ser_out,
    output sink_drive
  );
  modport ctl (
    output link_clk,
    output ser_in,
    output latch_load,
    output out_off,
    input  ser_out,
    input  sink_drive
  );
endinterface
`default_nettype wire

// *** rtl/ssd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssd_sync
  import ssd_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // Change accepted only when second and third stage agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/ssd_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssd_device
  import ssd_pkg::*;
#(
  parameter int N = STAGES
) (
  input  wire logic MCLK,
  input  wire logic NRST,
  ssd_if.dev        LINK
);
  logic [3:0]   pins;
  logic         clk_s;
  logic         clk_d_reg;
  logic [N-1:0] shift_reg;
  logic [N-1:0] latch_reg;
  logic         ser_reg;
  logic [7:0]   sink_reg;

  ssd_sync #(.W(4)) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .d     ({LINK.link_clk, LINK.ser_in, LINK.latch_load, LINK.out_off}),
    .q     (pins)
  );
  assign clk_s = pins[3];

  // ==========================================
  // Shift chain
  // ==========================================
  // cleared at start
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      clk_d_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      clk_d_reg <= clk_s;
      if (clk_s && !clk_d_reg) begin
        shift_reg <= {shift_reg[N-2:0], pins[2]};
      end
    end
  end

  // ==========================================
  // Latches
  // ==========================================
  // Latch samples the chain a cycle later, as a real latch sees settled data
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      latch_reg <= '0;
    end else begin
      if (pins[1]) begin
        latch_reg <= shift_reg;
      end
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ser_reg  <= 1'b0;
      sink_reg <= CLEAR_VAL;
    end else begin
      ser_reg <= shift_reg[N-1];
      sink_reg <= pins[0] ? CLEAR_VAL : latch_reg[7:0];
    end
  end

  assign LINK.ser_out    = ser_reg;
  assign LINK.sink_drive = sink_reg;
endmodule
`default_nettype wire

// *** rtl/ssd_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssd_ctrl
  import ssd_pkg::*;
#(
  parameter int N = STAGES
) (
  input  wire logic         MCLK,
  input  wire logic         NRST,
  input  wire logic         SEND,
  input  wire logic [N-1:0] DATA,
  input  wire logic         OUT_OFF,
  input  wire logic         TRANSPARENT,
  output logic              BUSY,
  ssd_if.ctl                LINK
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LOAD  = 2'b10
  } ssd_state_t;

  ssd_state_t   state_reg;
  logic [7:0]   div_reg;
  logic [7:0]   bit_reg;
  logic [N-1:0] data_reg;
  logic         lclk_reg;
  logic         sin_reg;
  logic         load_reg;
  logic         off_reg;
  logic         busy_reg;

  // ==========================================
  // Sequencer
  // ==========================================
  // divider keeps link clock at or below limit; MSB first so bit 8 lands last
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= 8'h00;
      data_reg  <= '0;
      lclk_reg  <= 1'b0;
      sin_reg   <= 1'b0;
      load_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          lclk_reg <= 1'b0;
          load_reg <= TRANSPARENT;
          if (SEND) begin
            data_reg  <= DATA;
            // First bit set up a full half period before the first rise
            sin_reg   <= DATA[N-1];
            bit_reg   <= 8'h00;
            div_reg   <= 8'h00;
            busy_reg  <= 1'b1;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          load_reg <= TRANSPARENT;
          if (div_reg == 8'(LINK_HALF_CYC - 1)) begin
            div_reg <= 8'h00;
            lclk_reg <= ~lclk_reg;
            // Data moves on the fall so it is settled at the next rise
            if (lclk_reg) begin
              sin_reg  <= data_reg[N-2];
              data_reg <= {data_reg[N-2:0], 1'b0};
              bit_reg  <= bit_reg + 8'h01;
              if (bit_reg == 8'(N - 1)) begin
                state_reg <= ST_LOAD;
              end
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        ST_LOAD: begin
          // Strobe pulse held one half link period
          load_reg <= 1'b1;
          if (div_reg == 8'(LINK_HALF_CYC - 1)) begin
            div_reg   <= 8'h00;
            busy_reg  <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // off on OUT_OFF request and while shifting in transparent mode
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      off_reg <= 1'b0;
    end else begin
      off_reg <= OUT_OFF || (TRANSPARENT && state_reg == ST_SHIFT);
    end
  end

  assign BUSY            = busy_reg;
  assign LINK.link_clk   = lclk_reg;
  assign LINK.ser_in     = sin_reg;
  assign LINK.latch_load = load_reg;
  assign LINK.out_off    = off_reg;
endmodule
`default_nettype wire

// *** testbench/ssd_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssd_assertions (
  input wire logic       MCLK,
  input wire logic       NRST,
  input wire logic       link_clk,
  input wire logic       ser_in,
  input wire logic       ser_out,
  input wire logic       latch_load,
  input wire logic       out_off,
  input wire logic [7:0] sink_drive
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // ====
  // Link checks
  property p_off; out_off [*8] |-> sink_drive == 8'h00; endproperty
  a_off: assert property (p_off)
    else $error("sinks on while off");
  property p_fall; $rose(out_off) |-> ##[1:8] sink_drive == 8'h00;
  endproperty
  a_fall: assert property (p_fall)
    else $error("sinks slow to switch off");
  property p_hold;
    (!latch_load && !out_off) [*8] |=> $stable(sink_drive);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch moved while closed");
  // Stage 8 leads sink 8 by one cycle
  property p_track; (latch_load && !out_off) [*8] ##0 $stable(ser_out) [*4]
    |-> sink_drive[7] == ser_out; endproperty
  a_track: assert property (p_track)
    else $error("open latch not tracking");
  property p_shift; $changed(ser_out) |-> link_clk && $past(link_clk, 3);
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift without link edge");
  property p_clear; disable iff (1'b0)
    !NRST && !$past(NRST) |-> sink_drive == 8'h00 && !ser_out; endproperty
  a_clear: assert property (p_clear)
    else $error("not clear in reset");
  property p_safe; $rose(link_clk) && latch_load |-> out_off; endproperty
  a_safe: assert property (p_safe)
    else $error("shifting into open latch");
  property p_rate;
    $changed(link_clk) |=> $stable(link_clk) [*8] ##1 $stable(link_clk) [*4];
  endproperty
  a_rate: assert property (p_rate)
    else $error("link clock too fast");
endmodule
`default_nettype wire

// *** testbench/tb_serial_in_latched_sink_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_serial_in_latched_sink_driver;
  logic       MCLK = 0, NRST = 0, SEND = 0, OUT_OFF = 0, TRANSPARENT = 0;
  logic       BUSY;
  logic [7:0] DATA = 8'h00;
  logic [8:0] exp_q[$];
  int         bad_count = 0, checked = 0, cyc = 0;
  event       look;
  ssd_if lnk();
  ssd_device u_ssd_device (.MCLK(MCLK), .NRST(NRST), .LINK(lnk));
  ssd_ctrl u_ssd_ctrl (.MCLK(MCLK), .NRST(NRST), .SEND(SEND), .DATA(DATA),
    .OUT_OFF(OUT_OFF), .TRANSPARENT(TRANSPARENT), .BUSY(BUSY), .LINK(lnk));
  ssd_assertions u_ssd_assertions (.MCLK(MCLK), .NRST(NRST),
    .link_clk(lnk.link_clk), .ser_in(lnk.ser_in), .ser_out(lnk.ser_out),
    .latch_load(lnk.latch_load), .out_off(lnk.out_off),
    .sink_drive(lnk.sink_drive));
  initial begin
    forever #2 MCLK = ~MCLK;
  end
  // ====
  // Tasks
  task wrap_up;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Margin covers three-stage sync plus latch and sink stages
  task settle(input logic [8:0] e);
    repeat (12) @(negedge MCLK);
    exp_q.push_back(e);
    -> look;
  endtask
  task send(input logic [7:0] d, input logic off, input logic tr);
    int n;
    @(negedge MCLK);
    {DATA, OUT_OFF, TRANSPARENT, SEND} = {d, off, tr, 1'b1};
    @(negedge MCLK);
    SEND = 0;
    n = 0;
    while (BUSY !== 1'b0 && n < 1000) begin
      @(negedge MCLK);
      n++;
    end
    settle({d[7], off ? 8'h00 : d});
  endtask
  // ====
  // Watch and run
  always @(look) begin
    logic [8:0] e;
    e = exp_q.pop_front();
    `CHK({lnk.ser_out, lnk.sink_drive}, e)
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("Error %0t: timeout", $time);
      wrap_up;
    end
  end
  initial begin
    logic [7:0] d;
    void'($urandom(33128));
    repeat (8) @(posedge MCLK);
    @(negedge MCLK) NRST = 1;
    settle(9'h000);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      send(d, i == 1, i > 2);
      if (i == 1) begin
        OUT_OFF = 0;
        settle({d[7], d});
      end
      $display("test %0d done", i);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
